// file: bench/tb_watchdog_supervisor.sv
// Self-checking bench of the watchdog supervisor.
// Assumes a zero-wait AHB-Lite slave; fs source gives short detection.
`timescale 1ns/100ps
module tb_watchdog_supervisor;
	reg clk_sys = 1'b0;
	reg rst_n = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg stopModePin = 1'b0;
	reg idleModePin = 1'b0;
	reg fsTickPin = 1'b0;
	reg nmiReturn = 1'b0;
	reg rdPhase = 1'b0;
	reg [2:0] fsDiv = 3'h0;
	reg [31:0] seed = 32'h2e1d;
	reg [31:0] expQ [$];
	wire [31:0] hrdata;
	wire hreadyout, hresp, watchdogIrq, resetPinOut, resetPinOe, resetRequest, trapCommit;
	wire [3:0] irqNestDepth;
	wire hready = hreadyout;
	wire [2:0] ev = {resetRequest, watchdogIrq, hready};
	integer badCount = 0;
	integer numChecks = 0;
	integer irqCount = 0;
	integer n;
	integer i;
	wds_watchdog_supervisor u_wds_watchdog_supervisor (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .stopModePin, .idleModePin, .fsTickPin,
		.nmiReturn, .watchdogIrq, .irqNestDepth, .resetPinOut, .resetPinOe, .resetRequest, .trapCommit);
	always #20 clk_sys = ~clk_sys;
	// Low-frequency tick, one rising edge every 8 cycles
	always @(posedge clk_sys)
	begin
		fsDiv <= fsDiv + 3'h1;
		fsTickPin <= fsDiv[2];
	end
	// Read data against the oldest note; interrupt count
	always @(posedge clk_sys)
	begin
		if (rdPhase)
			check(hrdata, expQ.pop_front());
		if (rdPhase)
			check({31'h0, hresp}, 32'h0);
		if (watchdogIrq === 1'b1)
			irqCount = irqCount + 1;
	end
	function [31:0] xs(input [31:0] v);
		reg [31:0] t;
		begin
			t = v ^ (v << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		begin
			numChecks = numChecks + 1;
			if (seen !== exp)
			begin
				badCount = badCount + 1;
				$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks=%0d mismatches=%0d", numChecks, badCount);
			if (badCount == 0 && numChecks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task waitEv(input integer s, input integer lim);
		begin
			n = 0;
			@(posedge clk_sys);
			while (ev[s] !== 1'b1 && n < lim)
			begin
				n = n + 1;
				@(posedge clk_sys);
			end
			if (ev[s] !== 1'b1)
			begin
				badCount = badCount + 1;
				conclude;
			end
		end
	endtask
	task bus(input [7:0] a, input w, input [31:0] d, input [31:0] e);
		begin
			{hsel, haddr, htrans, hwrite} <= {1'b1, 22'h0, a, 2'h0, 2'h2, w};
			waitEv(0, 100);
			htrans <= 2'h0;
			hwdata <= d;
			rdPhase <= !w;
			if (!w)
				expQ.push_back(e);
			waitEv(0, 100);
			rdPhase <= 1'b0;
		end
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		// Reset state, write-only and unmapped places, ignored codes, trap commit code
		bus(8'h3c, 0, 0, 32'h100);
		bus(8'h34, 0, 0, 0);
		bus(8'h40, 1, 32'hff, 0);
		bus(8'h40, 0, 0, 0);
		for (i = 0; i < 4; i = i + 1)
		begin
			seed = xs(seed);
			bus(8'h35, 1, (seed[7:0] == 8'h4e || seed[7:0] == 8'hb1 || seed[7:0] == 8'hd2) ? ~seed : seed, 0);
		end
		bus(8'h35, 1, 32'hb1, 0);
		bus(8'h35, 1, 32'hd2, 0);
		bus(8'h3c, 0, 0, 32'h100);
		// Stop sequence, then fast overflow with reset action
		bus(8'h35, 1, 32'h4e, 0);
		bus(8'h34, 1, 32'h07, 0);
		bus(8'h35, 1, 32'hb1, 0);
		bus(8'h3c, 0, 0, 32'h0);
		bus(8'h38, 1, 32'h1, 0);
		bus(8'h34, 1, 32'h0f, 0);
		waitEv(2, 20000);
		check({31'h0, n >= 12000 && n <= 16600}, 32'h1);
		repeat (30) @(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		// Interrupt action, locked against return to reset
		bus(8'h38, 1, 32'h1, 0);
		bus(8'h34, 1, 32'h0e, 0);
		bus(8'h34, 1, 32'h0f, 0);
		bus(8'h35, 1, 32'h4e, 0);
		bus(8'h3c, 0, 0, 32'h300);
		waitEv(1, 20000);
		waitEv(1, 20000);
		bus(8'h3c, 0, 0, 32'h308);
		nmiReturn <= 1'b1;
		@(posedge clk_sys);
		nmiReturn <= 1'b0;
		bus(8'h3c, 0, 0, 32'h304);
		// Keep-alive from the main flow, clears well inside three quarters
		bus(8'h35, 1, 32'h4e, 0);
		i = irqCount;
		repeat (3)
		begin
			repeat (5500) @(posedge clk_sys);
			bus(8'h35, 1, 32'h4e, 0);
		end
		check(irqCount - i, 32'h0);
		// Freeze in IDLE then STOP longer than the detection time
		i = irqCount;
		idleModePin <= 1'b1;
		repeat (8500) @(posedge clk_sys);
		idleModePin <= 1'b0;
		stopModePin <= 1'b1;
		repeat (8500) @(posedge clk_sys);
		stopModePin <= 1'b0;
		check(irqCount - i, 32'h0);
		repeat (6) @(posedge clk_sys);
		bus(8'h35, 1, 32'h4e, 0);
		waitEv(1, 20000);
		conclude;
	end
endmodule // tb_watchdog_supervisor
bind wds_watchdog_supervisor wds_sup_props u_wds_sup_props (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .stopModePin, .idleModePin, .nmiReturn, .watchdogIrq, .irqNestDepth, .resetPinOut, .resetPinOe,
	.resetRequest, .trapCommit);

// file: bench/wds_sup_props.sv
// Port checker of the watchdog supervisor.
// Assumes binding to wds_watchdog_supervisor, one clock.
`timescale 1ns/100ps
`include "wds_consts.vh"
module wds_sup_props
(
	input wire clk_sys,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire stopModePin,
	input wire idleModePin,
	input wire nmiReturn,
	input wire watchdogIrq,
	input wire [3:0] irqNestDepth,
	input wire resetPinOut,
	input wire resetPinOe,
	input wire resetRequest,
	input wire trapCommit
);
	reg wrCmd;
	reg [4:0] oeCnt;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Command write in its data phase; length of reset pin drive
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrCmd <= 1'b0;
			oeCnt <= 5'h00;
		end
		else
		begin
			wrCmd <= hsel && htrans[1] && hwrite && haddr == {22'h0, `WDS_OFS_CMD, 2'b00};
			oeCnt <= resetPinOe ? oeCnt + 5'h01 : 5'h00;
		end
	end
	chk_reset_follows: assert property (resetRequest |-> ##[0:1] (resetPinOe && !resetPinOut))
		else $error("reset pin not driven");
	chk_oe_cause: assert property ($rose(resetPinOe) |-> resetRequest || $past(resetRequest))
		else $error("reset pin without request");
	chk_oe_width: assert property ($fell(resetPinOe) |-> oeCnt == 5'h18)
		else $error("reset pin width wrong");
	chk_oe_bound: assert property (oeCnt <= 5'h18)
		else $error("reset pin too long");
	chk_one_request: assert property (watchdogIrq |-> !resetRequest ##1 !watchdogIrq)
		else $error("request not single");
	chk_depth_cause: assert property (irqNestDepth != $past(irqNestDepth) |->
		watchdogIrq || $past(watchdogIrq) || $past(nmiReturn) || $past(nmiReturn, 2))
		else $error("depth changed alone");
	chk_freeze_quiet: assert property ((idleModePin || stopModePin) [*8] |-> !watchdogIrq && !resetRequest)
		else $error("request while frozen");
	chk_trap_commit: assert property (trapCommit == ($past(wrCmd) && $past(hwdata[7:0]) == `WDS_CODE_TRAPSET))
		else $error("trap commit wrong");
endmodule // wds_sup_props

// file: core/wds_consts.vh
// Constants of the watchdog supervisor: register offsets, fields, codes, timing.
// Assumes inclusion by bare name from the design files of this block.
`ifndef WDS_CONSTS_VH
`define WDS_CONSTS_VH
// Register indices; the byte address on the bus is four times the index
`define WDS_OFS_CTRL1 8'h34
`define WDS_OFS_CMD 8'h35
`define WDS_OFS_MODE 8'h38
`define WDS_OFS_STAT 8'h3c
`define WDS_BIT_RUN 3
`define WDS_BIT_ACT 0
`define WDS_CTRL1_RST 4'h9
`define WDS_CODE_CLEAR 8'h4e
`define WDS_CODE_DISABLE 8'hb1
`define WDS_CODE_TRAPSET 8'hd2
`define WDS_FC_DIV 8'h01
`define WDS_FS_DIV 8'h02
`define WDS_RST_PULSE 8'h18
`define WDS_RST_FC_PERIODS 24
`define WDS_DIV_W 24
`endif

// file: core/wds_pin_sync.v
// Three-stage input synchroniser with agreement filter for one pin level.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/100ps
module wds_pin_sync
(
	input wire clk_sys,
	input wire rst_n,
	input wire pinIn,
	output reg pinOut
);
	reg stage1;
	reg stage2;
	reg stage3;
	// Shift chain; output follows once stages two and three agree
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			pinOut <= 1'b0;
		end
		else
		begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3)
				pinOut <= stage3;
		end
	end
endmodule // wds_pin_sync

// file: core/wds_watchdog_supervisor.v
// Watchdog supervisor: divider, two-stage binary counter, AHB-Lite register slave.
// Assumes one clk_sys, pin-level mode inputs, and that software follows the stop sequence.
//
// Behaviour
// [RULE1] Reset release sets overflow action to reset request.
// [RULE2] After action select written 0, writes of 1 ignored until reset.
// [RULE3] Run bit resets to 1; counting starts without software.
// [RULE4] Overflow with action 1 issues reset request and drives reset pin low.
// [RULE5] Overflow with action 0 raises non-maskable watchdog interrupt.
// [RULE6] New watchdog interrupt serviced at once, earlier one held pending.
// [RULE7] Counting freezes in STOP, warm-up, IDLE and SLEEP; resumes from held count. Code freezes on the STOP and IDLE pins only.
// [RULE8] Clear code clears only the binary counter, not the divider.
// [RULE9] Software clears more often than three quarters of detection time.
// [RULE10] Detection field picks 2^25..2^19 fc or 2^17..2^11 fs periods.
// [RULE11] Control one is write-only: run bit 3, time 2:1, action 0.
// [RULE12] Command decodes clear, disable and trap commit; others ignored.
// [RULE13] Disable code acts only when run bit is already 0.
// [RULE14] Software stop order: clear flag, clear code, run 0, disable code.
// [RULE15] While disabled the binary counters stay cleared.
// [RULE16] Software disables or clears before STOP and clears after it.
// [RULE17] Software never clears the counter from an interrupt routine.
// [RULE18] Software sets the stack pointer before choosing interrupt action.
// [RULE19] Watchdog reset holds the reset output at most 24 fc periods.
// [RULE20] One request per overflow; after interrupt counting continues wrapped.
`timescale 1ns/100ps
`include "wds_consts.vh"
module wds_watchdog_supervisor
(
	input wire clk_sys,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire stopModePin,
	input wire idleModePin,
	input wire fsTickPin,
	input wire nmiReturn,
	output reg watchdogIrq,
	output reg [3:0] irqNestDepth,
	output reg resetPinOut,
	output reg resetPinOe,
	output reg resetRequest,
	output reg trapCommit
);
	// Control and mode state
	reg watchdogRunBit;
	reg [1:0] detectionTimeSel;
	reg overflowActionSel;
	reg actionLocked;
	reg enabled;
	reg dividerSourceSel;
	reg slowMode;
	reg [`WDS_DIV_W-1:0] divider;
	reg [1:0] binCount;
	reg [7:0] rstPulse;
	reg fsPrev;
	// Bus capture
	reg wrPend;
	reg [7:0] wrAddr;
	wire stopSync;
	wire idleSync;
	wire fsSync;
	wire freeze;
	wire fcTick;
	wire fsTick;
	wire srcTick;
	reg stageTap;
	reg stageTapPrev;
	wire stageEdge;
	wire overflow;
	wire isClear;
	wire busAct;
	wire [7:0] wb;
	assign wb = hwdata[7:0];

	// Pin synchronisers for mode and low-frequency inputs
	wds_pin_sync uStop (.clk_sys(clk_sys), .rst_n(rst_n), .pinIn(stopModePin), .pinOut(stopSync));
	wds_pin_sync uIdle (.clk_sys(clk_sys), .rst_n(rst_n), .pinIn(idleModePin), .pinOut(idleSync));
	wds_pin_sync uFs (.clk_sys(clk_sys), .rst_n(rst_n), .pinIn(fsTickPin), .pinOut(fsSync));

	assign freeze = stopSync | idleSync; // RULE7
	assign fcTick = 1'b1;
	assign fsTick = fsSync & ~fsPrev;
	assign srcTick = (dividerSourceSel | slowMode) ? fsTick : fcTick;
	assign busAct = hsel & hready & htrans[1];
	assign isClear = wrPend && (wrAddr == `WDS_OFS_CMD) && (wb == `WDS_CODE_CLEAR);

	// Divider tap selects detection time: counter period is 4 taps
	always @*
	begin
		stageTap = 1'b0;
		if (dividerSourceSel | slowMode)
		begin
			case (detectionTimeSel) // RULE10
				2'b00: stageTap = divider[14];
				2'b01: stageTap = divider[12];
				2'b10: stageTap = divider[10];
				default: stageTap = divider[8];
			endcase
		end
		else
		begin
			case (detectionTimeSel) // RULE10
				2'b00: stageTap = divider[22];
				2'b01: stageTap = divider[20];
				2'b10: stageTap = divider[18];
				default: stageTap = divider[16];
			endcase
		end
	end
	assign stageEdge = stageTapPrev & ~stageTap;
	assign overflow = enabled && !freeze && stageEdge && (binCount == 2'b11) && !isClear;

	// Free divider, never cleared by software
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			divider <= {`WDS_DIV_W{1'b0}};
			stageTapPrev <= 1'b0;
			fsPrev <= 1'b0;
		end
		else
		begin
			fsPrev <= fsSync;
			if (!freeze && srcTick)
				divider <= divider + 1'b1; // RULE8
			if (!freeze)
				stageTapPrev <= stageTap; // RULE7
		end
	end

	// Two-stage binary counter
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			binCount <= 2'b00;
		else if (!enabled)
			binCount <= 2'b00; // RULE15
		else if (isClear)
			binCount <= 2'b00; // RULE8
		else if (!freeze && stageEdge)
			binCount <= binCount + 2'b01; // RULE20
	end

	// AHB-Lite slave: capture address phase, zero wait states, always OKAY
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wrPend <= busAct & hwrite;
			// Word index: one register per aligned word
			if (busAct)
				wrAddr <= haddr[9:2];
			if (busAct && !hwrite)
			begin
				case (haddr[9:2])
					`WDS_OFS_MODE: hrdata <= {30'h00000000, slowMode, dividerSourceSel};
					`WDS_OFS_STAT: hrdata <= {22'h000000, actionLocked, enabled, binCount, irqNestDepth, watchdogIrq, resetRequest};
					default: hrdata <= 32'h00000000; // RULE11
				endcase
			end
		end
	end

	// Register writes and command decode
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			watchdogRunBit <= 1'b1; // RULE3
			detectionTimeSel <= 2'b00;
			overflowActionSel <= 1'b1; // RULE1
			actionLocked <= 1'b0;
			enabled <= 1'b1;
			dividerSourceSel <= 1'b0;
			slowMode <= 1'b0;
			trapCommit <= 1'b0;
		end
		else
		begin
			trapCommit <= 1'b0;
			if (wrPend)
			begin
				case (wrAddr)
					`WDS_OFS_CTRL1:
					begin
						watchdogRunBit <= wb[`WDS_BIT_RUN]; // RULE11
						detectionTimeSel <= wb[2:1];
						if (wb[`WDS_BIT_RUN])
							enabled <= 1'b1;
						if (!wb[`WDS_BIT_ACT])
						begin
							overflowActionSel <= 1'b0;
							actionLocked <= 1'b1;
						end
						else if (!actionLocked)
							overflowActionSel <= 1'b1; // RULE2
					end
					`WDS_OFS_CMD:
					begin
						if (wb == `WDS_CODE_DISABLE && !watchdogRunBit)
							enabled <= 1'b0; // RULE13
						else if (wb == `WDS_CODE_TRAPSET)
							trapCommit <= 1'b1; // RULE12
					end
					`WDS_OFS_MODE:
					begin
						dividerSourceSel <= wb[0];
						slowMode <= wb[1];
					end
					default:
					begin
					end
				endcase
			end
		end
	end

	// Interrupt request and nesting depth: new one taken at once, old one pending
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			watchdogIrq <= 1'b0;
			irqNestDepth <= 4'h0;
		end
		else
		begin
			watchdogIrq <= overflow & ~overflowActionSel; // RULE5
			// Accept and return in one cycle leave a nonzero depth unchanged
			if (overflow && !overflowActionSel && (!nmiReturn || irqNestDepth == 4'h0) && irqNestDepth != 4'hf)
				irqNestDepth <= irqNestDepth + 4'h1; // RULE6
			else if (nmiReturn && !(overflow && !overflowActionSel) && irqNestDepth != 4'h0)
				irqNestDepth <= irqNestDepth - 4'h1;
		end
	end

	// Reset request and reset pin pulse of bounded length
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstPulse <= 8'h00;
			resetRequest <= 1'b0;
			resetPinOut <= 1'b1;
			resetPinOe <= 1'b0;
		end
		else
		begin
			resetRequest <= overflow & overflowActionSel; // RULE4
			if (overflow && overflowActionSel)
				rstPulse <= `WDS_RST_PULSE; // RULE19
			else if (rstPulse != 8'h00)
				rstPulse <= rstPulse - 8'h01;
			resetPinOe <= (overflow && overflowActionSel) || (rstPulse > 8'h01);
			resetPinOut <= 1'b0;
		end
	end
endmodule // wds_watchdog_supervisor
